// [rtl/gpio_ad_pkg.sv]
// Notes on behaviour
// RULE1: data read gives latch if output, else pin
// RULE2: input view always returns synchronised pin levels
// RULE3: writes to input view change nothing
// RULE4: direction bit 0 input, 1 output
// RULE5: input reads settle within five cycles after direction change
// RULE6: drive bit 0 full, 1 reduced; outputs only
// RULE7: pull enable acts on inputs, cleared at reset
// RULE8: no pull while converter channel enabled
// RULE9: pull select chooses up or down, inputs only
// RULE10: data latch is driven on general-purpose outputs
// RULE11: latch writes reach pin only on gp outputs
// RULE12: peripheral ownership overrides the direction bit
// RULE13: settings writable anytime, effective only when applicable
// RULE14: reset leaves every pin a general-purpose input
// RULE15: all port registers reset asynchronously
// RULE16: pins synchronised before register reads return them
package gpio_ad_pkg;

	localparam int unsigned PORT_W = 8;
	localparam int unsigned IDX_W  = 6;

	typedef logic [PORT_W-1:0] port_t;
	typedef logic [IDX_W-1:0]  reg_idx_t;

	// register word indices; byte address is four times the index
	localparam reg_idx_t IDX_PORT_OUTPUT_LATCH     = 6'h30;
	localparam reg_idx_t IDX_PIN_INPUT_VIEW        = 6'h31;
	localparam reg_idx_t IDX_DIRECTION_SELECT      = 6'h32;
	localparam reg_idx_t IDX_DRIVE_STRENGTH_SELECT = 6'h33;
	localparam reg_idx_t IDX_PULL_ENABLE           = 6'h34;
	localparam reg_idx_t IDX_PULL_POLARITY_SELECT  = 6'h35;

	// word index sits above the two byte-offset bits of the address
	localparam int unsigned ADR_IDX_LSB = 2;

	// reset values
	localparam port_t RST_PORT_OUTPUT_LATCH     = 8'h00;
	localparam port_t RST_DIRECTION_SELECT      = 8'h00;
	localparam port_t RST_DRIVE_STRENGTH_SELECT = 8'h00;
	localparam port_t RST_PULL_ENABLE           = 8'h00;
	localparam port_t RST_PULL_POLARITY_SELECT  = 8'h00;
	localparam port_t PORT_ZERO                 = 8'h00;
	localparam logic [31:0] BUS_ZERO            = 32'h0000_0000;

	// software-visible configuration
	typedef struct packed {
		port_t port_output_latch;
		port_t direction_select;
		port_t drive_strength_select;
		port_t pull_enable;
		port_t pull_polarity_select;
	} cfg_s;

	// values presented to the pad ring
	typedef struct packed {
		port_t pin_out;
		port_t pin_oe_n;
		port_t drive_reduced;
		port_t pull_up;
		port_t pull_down;
	} pad_s;

	// bus answer
	typedef struct packed {
		logic        ack;
		logic [31:0] dat;
	} bus_s;

	// whole state of the port block
	typedef struct packed {
		cfg_s cfg;
		pad_s pad;
		bus_s bus;
	} state_s;

endpackage

// [rtl/pin_sync.sv]
`timescale 1ns/1ps
`default_nettype none

// three-stage synchroniser; the output follows once stages two and three agree
module pin_sync
	import gpio_ad_pkg::*;
#(
	parameter int unsigned WIDTH = PORT_W
)
(
	// clock and reset
	input  wire logic             clk_i,
	input  wire logic             reset_n_i,
	// asynchronous levels in, stable levels out
	input  wire logic [WIDTH-1:0] async_i,
	output var  logic [WIDTH-1:0] sync_o
);

	typedef struct packed {
		logic [WIDTH-1:0] s1;
		logic [WIDTH-1:0] s2;
		logic [WIDTH-1:0] s3;
		logic [WIDTH-1:0] q;
	} sync_s;

	sync_s st;
	sync_s next_st;

	initial
	begin
		if (WIDTH < 1)
		begin
			$error("pin_sync needs at least one bit");
		end
	end

	always_comb
	begin
		next_st    = st;
		next_st.s1 = async_i;
		next_st.s2 = st.s1;
		next_st.s3 = st.s2;
		for (int i = 0; i < WIDTH; i++)
		begin
			if (st.s2[i] == st.s3[i])
			begin
				next_st.q[i] = st.s3[i];
			end
		end
	end

	always_ff @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			st <= '0; // RULE15
		end
		else
		begin
			st <= next_st;
		end
	end

	assign sync_o = st.q;

endmodule

`default_nettype wire

// [rtl/analog_port_gpio_control.sv]
`timescale 1ns/1ps
`default_nettype none

module analog_port_gpio_control
	import gpio_ad_pkg::*;
#(
	parameter int unsigned ADR_W = 8
)
(
	// clock and reset
	input  wire logic             clk_i,
	input  wire logic             reset_n_i,

	// classic wishbone slave
	input  wire logic             cyc_i,
	input  wire logic             stb_i,
	input  wire logic             we_i,
	input  wire logic [ADR_W-1:0] adr_i,
	input  wire logic [3:0]       sel_i,
	input  wire logic [31:0]      dat_i,
	output var  logic [31:0]      dat_o,
	output var  logic             ack_o,

	// pad levels from the pins
	input  wire logic [7:0]       pin_i,

	// peripheral sharing the pins
	input  wire logic [7:0]       periph_own_i,
	input  wire logic [7:0]       periph_oe_i,
	input  wire logic [7:0]       periph_out_i,

	// analog converter channel enables
	input  wire logic [7:0]       analog_converter_channel_i,

	// pad controls
	output var  logic [7:0]       pin_o,
	output var  logic [7:0]       pin_oe_n_o,
	output var  logic [7:0]       drive_reduced_o,
	output var  logic [7:0]       pull_up_o,
	output var  logic [7:0]       pull_down_o
);

	state_s st;
	state_s next_st;
	port_t  pin_sync_q;

	initial
	begin
		if (ADR_W < IDX_W + ADR_IDX_LSB)
		begin
			$error("address bus too narrow for the register map");
		end
		// pin ports are fixed at one byte
		if ($bits(pin_i) != PORT_W)
		begin
			$error("pin ports do not match the port width");
		end
	end

	// byte lane 0 carries the 8-bit registers
	function automatic port_t lane_merge(input port_t old_v, input logic [31:0] d,
	                                     input logic lane_en);
		port_t r;
		r = old_v;
		if (lane_en)
		begin
			r = d[PORT_W-1:0];
		end
		return r;
	endfunction

	// per pin select between two vectors
	function automatic port_t pick(input port_t sel, input port_t one_v, input port_t zero_v);
		return (sel & one_v) | (~sel & zero_v);
	endfunction

	// a wider bus must not alias the map: address bits above the index stay clear
	function automatic logic upper_clear(input logic [ADR_W-1:0] a);
		logic [ADR_W-1:0] hi;
		hi = a >> (IDX_W + ADR_IDX_LSB);
		return (hi == '0);
	endfunction

	// word indices that answer with a register
	function automatic logic is_mapped(input reg_idx_t i);
		logic hit;
		case (i)
			IDX_PORT_OUTPUT_LATCH,
			IDX_PIN_INPUT_VIEW,
			IDX_DIRECTION_SELECT,
			IDX_DRIVE_STRENGTH_SELECT,
			IDX_PULL_ENABLE,
			IDX_PULL_POLARITY_SELECT:
			begin
				hit = 1'b1;
			end
			default:
			begin
				hit = 1'b0;
			end
		endcase
		return hit;
	endfunction

	// read value of one word; bits above the byte read zero
	function automatic logic [31:0] read_word(input reg_idx_t i,
	                                          input cfg_s     cfg,
	                                          input port_t    data_v,
	                                          input port_t    pins);
		logic [31:0] w;
		w = BUS_ZERO;
		case (i)
			IDX_PORT_OUTPUT_LATCH:
			begin
				w[PORT_W-1:0] = data_v; // RULE1
			end
			IDX_PIN_INPUT_VIEW:
			begin
				w[PORT_W-1:0] = pins; // RULE2
			end
			IDX_DIRECTION_SELECT:
			begin
				w[PORT_W-1:0] = cfg.direction_select;
			end
			IDX_DRIVE_STRENGTH_SELECT:
			begin
				w[PORT_W-1:0] = cfg.drive_strength_select;
			end
			IDX_PULL_ENABLE:
			begin
				w[PORT_W-1:0] = cfg.pull_enable;
			end
			IDX_PULL_POLARITY_SELECT:
			begin
				w[PORT_W-1:0] = cfg.pull_polarity_select;
			end
			default:
			begin
				w = BUS_ZERO;
			end
		endcase
		return w;
	endfunction

	// pad controls from the per-pin modes
	function automatic pad_s pad_next(input cfg_s  cfg,
	                                  input port_t out_m,
	                                  input port_t value,
	                                  input port_t pull_m);
		pad_s p;
		p.pin_out       = value; // RULE10 RULE11
		p.pin_oe_n      = ~out_m; // RULE4
		p.drive_reduced = cfg.drive_strength_select & out_m; // RULE6 RULE13
		p.pull_up       = pull_m & ~cfg.pull_polarity_select; // RULE9
		p.pull_down     = pull_m & cfg.pull_polarity_select; // RULE9
		return p;
	endfunction

	pin_sync #(
		.WIDTH (PORT_W)
	) u_pin_sync (
		.clk_i     (clk_i),
		.reset_n_i (reset_n_i),
		.async_i   (pin_i),
		.sync_o    (pin_sync_q) // RULE16
	);

	reg_idx_t adr_idx;
	logic     req;
	logic     adr_hit;
	port_t    gp_out;
	port_t    gp_in;
	port_t    per_out;
	port_t    per_in;
	port_t    out_mode;
	port_t    in_mode;
	port_t    out_value;
	port_t    pull_on;
	port_t    data_view;

	always_comb
	begin
		adr_idx = adr_i[ADR_IDX_LSB +: IDX_W];
		req     = cyc_i & stb_i & ~st.bus.ack;
		adr_hit = upper_clear(adr_i) & is_mapped(adr_idx);
	end

	always_comb
	begin
		// peripheral ownership replaces the direction bit
		gp_out    = ~periph_own_i & st.cfg.direction_select; // RULE4
		gp_in     = ~periph_own_i & ~st.cfg.direction_select; // RULE4
		per_out   = periph_own_i & periph_oe_i; // RULE12
		per_in    = periph_own_i & ~periph_oe_i; // RULE12
		out_mode  = gp_out | per_out;
		in_mode   = gp_in | per_in;
		// latch reaches the pin only for general-purpose outputs
		out_value = pick(periph_own_i, periph_out_i, st.cfg.port_output_latch); // RULE10 RULE11
		// pulls only on inputs and never on an active converter channel
		pull_on   = st.cfg.pull_enable & in_mode & ~analog_converter_channel_i; // RULE7 RULE8
		// data read: latch for output bits, synchronised pin otherwise
		data_view = pick(st.cfg.direction_select, st.cfg.port_output_latch,
		                 pin_sync_q); // RULE1 RULE5
	end

	always_comb
	begin
		next_st = st;

		// pad controls, registered so every output comes from a flop
		next_st.pad = pad_next(st.cfg, out_mode, out_value, pull_on);

		// one-cycle ack, dropped the cycle after
		next_st.bus.ack = req;
		next_st.bus.dat = BUS_ZERO;

		if (req)
		begin
			if (!adr_hit)
			begin
				// unmapped word: acknowledged, reads zero, write dropped
				next_st.bus.dat = BUS_ZERO;
			end
			else if (we_i)
			begin
				// every configuration register takes writes at any time
				case (adr_idx)
					IDX_PORT_OUTPUT_LATCH:
					begin
						next_st.cfg.port_output_latch =
							lane_merge(st.cfg.port_output_latch, dat_i, sel_i[0]); // RULE11 RULE13
					end
					IDX_DIRECTION_SELECT:
					begin
						next_st.cfg.direction_select =
							lane_merge(st.cfg.direction_select, dat_i, sel_i[0]); // RULE13
					end
					IDX_DRIVE_STRENGTH_SELECT:
					begin
						next_st.cfg.drive_strength_select =
							lane_merge(st.cfg.drive_strength_select, dat_i, sel_i[0]); // RULE13
					end
					IDX_PULL_ENABLE:
					begin
						next_st.cfg.pull_enable =
							lane_merge(st.cfg.pull_enable, dat_i, sel_i[0]); // RULE13
					end
					IDX_PULL_POLARITY_SELECT:
					begin
						next_st.cfg.pull_polarity_select =
							lane_merge(st.cfg.pull_polarity_select, dat_i, sel_i[0]); // RULE13
					end
					IDX_PIN_INPUT_VIEW:
					begin
						// read-only view: write is acknowledged and dropped
						next_st.cfg = st.cfg; // RULE3
					end
					default:
					begin
						next_st.cfg = st.cfg;
					end
				endcase
			end
			else
			begin
				next_st.bus.dat = read_word(adr_idx, st.cfg, data_view, pin_sync_q);
			end
		end
	end

	always_ff @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			// RULE15
			st.cfg.port_output_latch     <= RST_PORT_OUTPUT_LATCH;
			st.cfg.direction_select      <= RST_DIRECTION_SELECT; // RULE14
			st.cfg.drive_strength_select <= RST_DRIVE_STRENGTH_SELECT;
			st.cfg.pull_enable           <= RST_PULL_ENABLE; // RULE7
			st.cfg.pull_polarity_select  <= RST_PULL_POLARITY_SELECT;
			st.pad.pin_out               <= PORT_ZERO;
			st.pad.pin_oe_n              <= ~PORT_ZERO; // RULE14
			st.pad.drive_reduced         <= PORT_ZERO;
			st.pad.pull_up               <= PORT_ZERO;
			st.pad.pull_down             <= PORT_ZERO;
			st.bus.ack                   <= 1'b0;
			st.bus.dat                   <= BUS_ZERO;
		end
		else
		begin
			st <= next_st;
		end
	end

	always_comb
	begin
		dat_o           = st.bus.dat;
		ack_o           = st.bus.ack;
		pin_o           = st.pad.pin_out;
		pin_oe_n_o      = st.pad.pin_oe_n;
		drive_reduced_o = st.pad.drive_reduced;
		pull_up_o       = st.pad.pull_up;
		pull_down_o     = st.pad.pull_down;
	end

endmodule

`default_nettype wire

// [test/gpio_ad_props.sv]
`timescale 1ns/1ps
`default_nettype none
module gpio_ad_props
(
	// watched ports
	input wire logic       clk_i,
	input wire logic       reset_n_i,
	input wire logic       cyc_i,
	input wire logic       stb_i,
	input wire logic       ack_o,
	input wire logic [7:0] periph_own_i,
	input wire logic [7:0] periph_oe_i,
	input wire logic [7:0] analog_converter_channel_i,
	input wire logic [7:0] pin_oe_n_o,
	input wire logic [7:0] drive_reduced_o,
	input wire logic [7:0] pull_up_o,
	input wire logic [7:0] pull_down_o
);
	wire logic [7:0] pulls = pull_up_o | pull_down_o;
	default clocking @(posedge clk_i); endclocking
	default disable iff (!reset_n_i);
	a_ack_single: assert property (ack_o |=> !ack_o)
		else $error("ack too long");
	a_ack_answer: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
		else $error("no ack");
	a_pull_analog: assert property ((pulls & $past(analog_converter_channel_i)) == 8'h00)
		else $error("pull on converter pin");
	a_pull_out: assert property ((pulls & ~pin_oe_n_o) == 8'h00)
		else $error("pull on output");
	a_pull_excl: assert property ((pull_up_o & pull_down_o) == 8'h00)
		else $error("both pulls");
	a_drive_in: assert property ((drive_reduced_o & pin_oe_n_o) == 8'h00)
		else $error("reduced drive on input");
	a_own_dir: assert property (
		((pin_oe_n_o ~^ $past(periph_oe_i)) & $past(periph_own_i)) == 8'h00)
		else $error("owner direction ignored");
	a_reset_in: assert property ($rose(reset_n_i) |-> pin_oe_n_o == 8'hff)
		else $error("not input after reset");
endmodule
bind analog_port_gpio_control gpio_ad_props u_props (
	.clk_i, .reset_n_i, .cyc_i, .stb_i, .ack_o, .periph_own_i, .periph_oe_i,
	.analog_converter_channel_i, .pin_oe_n_o, .drive_reduced_o, .pull_up_o, .pull_down_o
);
`default_nettype wire

// [test/pad_model.sv]
`timescale 1ns/1ps
`default_nettype none
module pad_model
(
	// pad controls
	input  wire logic [7:0] pin_o,
	input  wire logic [7:0] pin_oe_n_o,
	input  wire logic [7:0] pull_up_o,
	input  wire logic [7:0] pull_down_o,
	// level of a floating pin
	input  wire logic [7:0] float_i,
	// pin levels
	output wire logic [7:0] pin_i
);
	assign pin_i = (~pin_oe_n_o & pin_o)
		| (pin_oe_n_o & (pull_up_o | (~pull_down_o & float_i)));
endmodule
`default_nettype wire

// [test/tb.sv]
`timescale 1ns/1ps
`default_nettype none
module tb;
	import gpio_ad_pkg::*;
	logic        clk_i = 1'b0, reset_n_i = 1'b0;
	logic        cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
	logic [7:0]  adr_i = 8'h00;
	logic [3:0]  sel_i = 4'h0;
	logic [31:0] dat_i = 32'h0, dat_o;
	logic        ack_o;
	port_t       pin_i, pin_o, oe_n, drv, pu, pd, q, c [6];
	port_t       own = 8'h00, poe = 8'h00, pout = 8'h00, adc = 8'h00, flt = 8'h00;
	int          n_mismatch = 0, n_checks = 0;

	always #12.5 clk_i = ~clk_i;

	analog_port_gpio_control dut (
		.clk_i, .reset_n_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o,
		.ack_o, .pin_i, .periph_own_i(own), .periph_oe_i(poe), .periph_out_i(pout),
		.analog_converter_channel_i(adc), .pin_o, .pin_oe_n_o(oe_n),
		.drive_reduced_o(drv), .pull_up_o(pu), .pull_down_o(pd)
	);
	pad_model u_pads (
		.pin_o, .pin_oe_n_o(oe_n), .pull_up_o(pu), .pull_down_o(pd), .float_i(flt), .pin_i
	);

	task automatic chk(input port_t got, input port_t exp);
		n_checks++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("BAD %0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic results();
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	task automatic wb(input logic w, input reg_idx_t i, input port_t d, input logic s,
		output port_t r);
		int n;
		n = 0;
		@(posedge clk_i);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= w;
		sel_i <= {3'h0, s};
		adr_i <= {i, 2'h0};
		dat_i <= {24'h0, d};
		do
		begin
			@(posedge clk_i);
			n++;
		end
		while (ack_o !== 1'b1 && n < 9);
		if (ack_o !== 1'b1)
		begin
			n_mismatch++;
			results();
		end
		else
		begin
			r = dat_o[7:0];
			cyc_i <= 1'b0;
			stb_i <= 1'b0;
		end
	endtask

	// pad outputs and both data views against the stored setup
	task automatic pads();
		port_t e;
		port_t p;
		port_t v;
		e = (own & poe) | (~own & c[2]);
		p = c[4] & ~e & ~adc;
		v = (own & pout) | (~own & c[0]);
		v = (e & v) | (~e & p & ~c[5]) | (~e & ~p & flt);
		chk(oe_n, ~e);
		chk(pin_o & e, v & e);
		chk(drv, c[3] & e);
		chk(pu, p & ~c[5]);
		chk(pd, p & c[5]);
		wb(1'b0, 6'h30, 8'h00, 1'b1, q);
		chk(q, (c[2] & c[0]) | (~c[2] & v));
		wb(1'b0, 6'h31, 8'h00, 1'b1, q);
		chk(q, v);
	endtask

	initial
	begin
		void'($urandom(32'h58263f92));
		c = '{default: 8'h00};
		repeat (2) @(posedge clk_i);
		reset_n_i <= 1'b1;
		for (int r = 0; r < 2; r++)
		begin
			for (int i = 0; i < 6; i++)
			begin
				wb(1'b0, 6'h30 + 6'(i), 8'h00, 1'b1, q);
				if (i != 1)
					chk(q, c[i]);
			end
			// disabled lane, read-only view, unmapped word
			wb(1'b1, 6'h32, 8'hff, 1'b0, q);
			wb(1'b1, 6'h31, 8'hff, 1'b1, q);
			wb(1'b1, 6'h3f, 8'hff, 1'b1, q);
			wb(1'b0, 6'h3f, 8'h00, 1'b1, q);
			chk(q, 8'h00);
			repeat (6) @(posedge clk_i);
			pads();
			$display("test reset %0d done", r);
			for (int t = 0; t < 30; t++)
			begin
				for (int i = 0; i < 6; i++)
					if (i != 1)
					begin
						c[i] = 8'($urandom);
						wb(1'b1, 6'h30 + 6'(i), c[i], 1'b1, q);
					end
				own <= (t < 2) ? 8'h00 : 8'($urandom);
				adc <= (t == 1) ? 8'hff : 8'($urandom);
				poe <= 8'($urandom);
				pout <= 8'($urandom);
				flt <= 8'($urandom);
				for (int i = 2; i < 6; i++)
				begin
					wb(1'b0, 6'h30 + 6'(i), 8'h00, 1'b1, q);
					chk(q, c[i]);
				end
				repeat (6) @(posedge clk_i);
				pads();
			end
			$display("test random %0d done", r);
			own <= 8'h00;
			flt <= 8'h00;
			reset_n_i <= 1'b0;
			@(negedge clk_i);
			chk(oe_n, 8'hff);
			@(posedge clk_i);
			reset_n_i <= 1'b1;
			c = '{default: 8'h00};
		end
		results();
	end
endmodule
`default_nettype wire
